// ===== include/cpc_pkg.sv
// Shared constants and types of the core register bank: special
// function register map, reset values, timing counts and carriers.
// Assumes a single system clock; used by every design file.
package cpc_pkg;

	// ==============================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned CLKS_PER_ICYC = 4;
	localparam logic [1:0] PH_LAST = 2'(CLKS_PER_ICYC - 1);
	localparam logic [1:0] PH_FIRST = 2'h0;
	localparam int unsigned TMR_SLOW_CLKS = 12;
	localparam int unsigned TMR_FAST_CLKS = 4;
	localparam logic [3:0] TMR_SLOW_TERM = 4'(TMR_SLOW_CLKS - 1);
	localparam logic [3:0] TMR_FAST_TERM = 4'(TMR_FAST_CLKS - 1);
	localparam logic [3:0] TMR_FIRST = 4'h0;
	localparam logic [3:0] MIN_ICYC = 4'h1;
	localparam logic [3:0] DMOVE_ICYC = 4'h3;
	localparam logic [3:0] XMOVE_BASE = 4'h2;
	localparam logic [3:0] MULDIV_ICYC = 4'h5;
	localparam logic [5:0] ELAPSED_ONE = 6'h01;

	// ==============================================================
	// Register map
	localparam logic [7:0] ADR_PORT0_PINS = 8'h80;
	localparam logic [7:0] ADR_STACK_POINTER = 8'h81;
	localparam logic [7:0] ADR_POINTER_A_LOW = 8'h82;
	localparam logic [7:0] ADR_POINTER_A_HIGH = 8'h83;
	localparam logic [7:0] ADR_POINTER_B_LOW = 8'h84;
	localparam logic [7:0] ADR_POINTER_B_HIGH = 8'h85;
	localparam logic [7:0] ADR_POINTER_CHOICE = 8'h86;
	localparam logic [7:0] ADR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADR_TIMER_MODES = 8'h89;
	localparam logic [7:0] ADR_TIMER0_COUNT_LOW = 8'h8A;
	localparam logic [7:0] ADR_TIMER1_COUNT_LOW = 8'h8B;
	localparam logic [7:0] ADR_TIMER0_COUNT_HIGH = 8'h8C;
	localparam logic [7:0] ADR_TIMER1_COUNT_HIGH = 8'h8D;
	localparam logic [7:0] ADR_CLOCK_RATE_CONTROL = 8'h8E;

	// ==============================================================
	// Fields
	localparam int unsigned SEL_BIT = 0;
	localparam logic [7:0] PWR_FIXED_ONES = 8'h30;
	localparam int unsigned FAST_LSB = 3;
	localparam int unsigned NUM_TIMERS = 3;

	// ==============================================================
	// Reset values
	localparam logic [7:0] PORT0_RST = 8'hFF;
	localparam logic [7:0] STACK_RST = 8'h00;
	localparam logic [7:0] RATE_RST = 8'h01;
	localparam logic [7:0] ZERO_RST = 8'h00;

	// ==============================================================
	// Types
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b01,
		SEQ_RUN = 2'b10
	} cpc_seq_type;

	typedef enum logic [1:0] {
		OP_PLAIN = 2'h0,
		OP_DIRECT_MOVE = 2'h1,
		OP_EXT_MOVE = 2'h2,
		OP_MULTIPLY = 2'h3
	} cpc_kind_type;

	typedef struct packed {
		cpc_kind_type kind;
		logic [1:0] bytes;
	} cpc_op_type;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} cpc_sfr_req_type;

	typedef struct packed {
		logic [7:0] port0_pins;
		logic [7:0] stack_pointer;
		logic [7:0] pointer_a_low;
		logic [7:0] pointer_a_high;
		logic [7:0] pointer_b_low;
		logic [7:0] pointer_b_high;
		logic pointer_choice;
		logic [7:0] power_control;
		logic [7:0] timer_control;
		logic [7:0] timer_modes;
		logic [7:0] timer0_count_low;
		logic [7:0] timer1_count_low;
		logic [7:0] timer0_count_high;
		logic [7:0] timer1_count_high;
		logic [7:0] clock_rate_control;
	} cpc_regs_type;

	localparam cpc_regs_type REGS_RST = '{PORT0_RST, STACK_RST,
		ZERO_RST, ZERO_RST, ZERO_RST, ZERO_RST, 1'b0, PWR_FIXED_ONES,
		ZERO_RST, ZERO_RST, ZERO_RST, ZERO_RST, ZERO_RST, ZERO_RST,
		RATE_RST};

	typedef struct packed {
		cpc_regs_type regs;
		logic [7:0] rdata;
		cpc_seq_type seq;
		logic [3:0] left;
		cpc_kind_type kind;
		logic [1:0] bytes;
		logic [2:0] stretch;
		logic [5:0] elapsed;
	} cpc_core_state_type;

	typedef struct packed {
		logic [1:0] phase;
	} cpc_phase_state_type;

	typedef struct packed {
		logic [3:0] count;
	} cpc_tick_state_type;

endpackage : cpc_pkg

// ===== design/cpc_icycle_gen.sv
// Instruction cycle phase generator: marks the last clock of each
// four-clock instruction cycle. Assumes a synchronous reset.
`timescale 1ns/1ps
module cpc_icycle_gen
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	output logic o_last
);
	import cpc_pkg::*;

	cpc_phase_state_type st_q;
	cpc_phase_state_type st_d;

	// ==============================================================
	// Phase counter
	always_comb
	begin
		st_d = st_q;
		st_d.phase = st_q.phase + 2'h1;
		if (st_q.phase == PH_LAST)
			st_d.phase = PH_FIRST; // RULE1
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			st_q <= '{phase: PH_FIRST};
		else
			st_q <= st_d;
	end

	assign o_last = (st_q.phase == PH_LAST);

endmodule : cpc_icycle_gen

// ===== design/cpc_rate_tick.sv
// One timer increment strobe: every twelve clocks, or every four
// when the fast bit is set. Assumes a synchronous reset.
`timescale 1ns/1ps
module cpc_rate_tick
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_fast,
	output logic o_tick
);
	import cpc_pkg::*;

	cpc_tick_state_type st_q;
	cpc_tick_state_type st_d;
	logic [3:0] term;

	// ==============================================================
	// Prescaler
	// A rate change mid-period wraps at once rather than overrunning
	assign term = i_fast ? TMR_FAST_TERM : TMR_SLOW_TERM; // RULE5 RULE6

	always_comb
	begin
		st_d = st_q;
		st_d.count = st_q.count + 4'h1;
		if (st_q.count >= term)
			st_d.count = TMR_FIRST;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			st_q <= '{count: TMR_FIRST};
		else
			st_q <= st_d;
	end

	assign o_tick = (st_q.count == TMR_FIRST);

endmodule : cpc_rate_tick

// ===== design/cpc_sfr_core.sv
// Core register bank for the low special function registers, the
// dual data pointers, instruction cycle timing and timer rates.
// Assumes the core's own register access port and one clock.
`timescale 1ns/1ps

// How it works
// RULE1 - One instruction cycle is four system clocks.
// RULE2 - Instructions last one to five instruction cycles.
// RULE3 - Pointer external read takes eight clocks; direct move twelve.
// RULE4 - Cycles follow byte count; multiply takes more than its bytes.
// RULE5 - Timers advance every twelve clocks after reset.
// RULE6 - Each timer may instead advance every four clocks.
// RULE7 - Clock rate bits 3, 4, 5 pick fast rate for timers 0, 1, 2.
// RULE8 - First pointer lives at 0x82 low and 0x83 high.
// RULE9 - Second pointer lives at 0x84 low and 0x85 high.
// RULE10 - Bit 0 at 0x86 selects first (0) or second (1) pointer.
// RULE11 - Other bits at 0x86 ignore writes and read zero.
// RULE12 - Pointer instructions act on the currently selected pointer.
// RULE13 - Incrementing 0x86 toggles the active pointer in one step.
// RULE14 - Fixed bits ignore writes and read their fixed value.
// RULE15 - Unused bits are plain storage without function.
// RULE16 - Software must not write unassigned addresses.
// RULE17 - Power-on and watchdog reset restore all reset values.
// RULE18 - External move takes two plus stretch cycles, three default.
// RULE19 - Pointer byte reads return stored value whatever is selected.
module cpc_sfr_core
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_wdt_rst,
	input wire cpc_pkg::cpc_sfr_req_type i_sfr,
	output logic [7:0] o_sfr_rdata,
	input wire logic i_ptr_load,
	input wire logic [15:0] i_ptr_value,
	input wire logic i_ptr_inc,
	output logic [15:0] o_data_pointer,
	output logic o_pointer_sel,
	input wire logic i_op_valid,
	input wire cpc_pkg::cpc_op_type i_op,
	output logic o_op_ready,
	output logic o_op_done,
	output logic o_icycle_end,
	output logic [2:0] o_timer_tick,
	output logic [2:0] o_stretch,
	output cpc_pkg::cpc_regs_type o_regs
);
	import cpc_pkg::*;

	cpc_core_state_type st_q;
	cpc_core_state_type st_d;
	logic rst;
	logic icyc_last;
	logic accept;
	logic finish;
	logic [7:0] rd_val;
	logic [15:0] ptr_act;
	logic [15:0] ptr_new;

	// ==============================================================
	// Cycle count per instruction
	function automatic logic [3:0] icyc_count(
		input cpc_op_type op,
		input logic [2:0] stretch
	);
		logic [3:0] n;
		n = {2'h0, op.bytes}; // RULE4
		unique case (op.kind)
		OP_PLAIN:
		begin
			if (op.bytes == 2'h0)
				n = MIN_ICYC; // RULE2
		end
		OP_DIRECT_MOVE:
			n = DMOVE_ICYC; // RULE3
		OP_EXT_MOVE:
			n = XMOVE_BASE + {1'b0, stretch}; // RULE18 RULE3
		OP_MULTIPLY:
			n = MULDIV_ICYC; // RULE4
		endcase
		return n;
	endfunction : icyc_count

	// Either reset source restores the whole bank
	assign rst = i_sys_rst | i_wdt_rst; // RULE17

	// ==============================================================
	// Instruction cycle and timer rate generators
	cpc_icycle_gen u_icyc
	(
		.i_sys_clk(i_sys_clk),
		.i_rst(rst),
		.o_last(icyc_last)
	);

	for (genvar gi = 0; gi < NUM_TIMERS; gi++)
	begin : g_tick
		cpc_rate_tick u_tick
		(
			.i_sys_clk(i_sys_clk),
			.i_rst(rst),
			.i_fast(st_q.regs.clock_rate_control[FAST_LSB + gi]), // RULE7
			.o_tick(o_timer_tick[gi])
		);
	end

	// ==============================================================
	// Active pointer
	assign ptr_act = st_q.regs.pointer_choice ?
		{st_q.regs.pointer_b_high, st_q.regs.pointer_b_low} :
		{st_q.regs.pointer_a_high, st_q.regs.pointer_a_low}; // RULE12

	// ==============================================================
	// Register read mux
	always_comb
	begin
		rd_val = 8'h00;
		unique case (i_sfr.addr)
		ADR_PORT0_PINS:
			rd_val = st_q.regs.port0_pins;
		ADR_STACK_POINTER:
			rd_val = st_q.regs.stack_pointer;
		ADR_POINTER_A_LOW:
			rd_val = st_q.regs.pointer_a_low; // RULE19
		ADR_POINTER_A_HIGH:
			rd_val = st_q.regs.pointer_a_high; // RULE19
		ADR_POINTER_B_LOW:
			rd_val = st_q.regs.pointer_b_low; // RULE19
		ADR_POINTER_B_HIGH:
			rd_val = st_q.regs.pointer_b_high; // RULE19
		ADR_POINTER_CHOICE:
			rd_val = {7'h00, st_q.regs.pointer_choice}; // RULE11
		ADR_POWER_CONTROL:
			rd_val = st_q.regs.power_control | PWR_FIXED_ONES; // RULE14
		ADR_TIMER_CONTROL:
			rd_val = st_q.regs.timer_control;
		ADR_TIMER_MODES:
			rd_val = st_q.regs.timer_modes;
		ADR_TIMER0_COUNT_LOW:
			rd_val = st_q.regs.timer0_count_low;
		ADR_TIMER1_COUNT_LOW:
			rd_val = st_q.regs.timer1_count_low;
		ADR_TIMER0_COUNT_HIGH:
			rd_val = st_q.regs.timer0_count_high;
		ADR_TIMER1_COUNT_HIGH:
			rd_val = st_q.regs.timer1_count_high;
		ADR_CLOCK_RATE_CONTROL:
			rd_val = st_q.regs.clock_rate_control;
		default:
			rd_val = 8'h00;
		endcase
	end

	// ==============================================================
	// Instruction sequencer handshake
	// Accepting in the finishing cycle lets instructions run back to back
	assign finish = (st_q.seq == SEQ_RUN) && icyc_last &&
		(st_q.left == MIN_ICYC);
	assign accept = i_op_valid && icyc_last &&
		((st_q.seq == SEQ_IDLE) || finish); // RULE1

	// ==============================================================
	// Next state
	always_comb
	begin
		st_d = st_q;
		ptr_new = ptr_act;

		// Core pointer operations go to the selected pointer
		if (i_ptr_load)
			ptr_new = i_ptr_value; // RULE12
		else if (i_ptr_inc)
			ptr_new = ptr_act + 16'h0001; // RULE12
		if (st_q.regs.pointer_choice)
		begin
			st_d.regs.pointer_b_high = ptr_new[15:8];
			st_d.regs.pointer_b_low = ptr_new[7:0];
		end
		else
		begin
			st_d.regs.pointer_a_high = ptr_new[15:8];
			st_d.regs.pointer_a_low = ptr_new[7:0];
		end

		// A register write of a pointer byte wins over a pointer op
		if (i_sfr.wr)
		begin
			unique case (i_sfr.addr)
			ADR_PORT0_PINS:
				st_d.regs.port0_pins = i_sfr.wdata;
			ADR_STACK_POINTER:
				st_d.regs.stack_pointer = i_sfr.wdata;
			ADR_POINTER_A_LOW:
				st_d.regs.pointer_a_low = i_sfr.wdata; // RULE8
			ADR_POINTER_A_HIGH:
				st_d.regs.pointer_a_high = i_sfr.wdata; // RULE8
			ADR_POINTER_B_LOW:
				st_d.regs.pointer_b_low = i_sfr.wdata; // RULE9
			ADR_POINTER_B_HIGH:
				st_d.regs.pointer_b_high = i_sfr.wdata; // RULE9
			ADR_POINTER_CHOICE:
				// Upper bits read zero, so an increment flips the select
				st_d.regs.pointer_choice = i_sfr.wdata[SEL_BIT]; // RULE10 RULE13
			ADR_POWER_CONTROL:
				st_d.regs.power_control = i_sfr.wdata | PWR_FIXED_ONES; // RULE14 RULE15
			ADR_TIMER_CONTROL:
				st_d.regs.timer_control = i_sfr.wdata;
			ADR_TIMER_MODES:
				st_d.regs.timer_modes = i_sfr.wdata;
			ADR_TIMER0_COUNT_LOW:
				st_d.regs.timer0_count_low = i_sfr.wdata;
			ADR_TIMER1_COUNT_LOW:
				st_d.regs.timer1_count_low = i_sfr.wdata;
			ADR_TIMER0_COUNT_HIGH:
				st_d.regs.timer0_count_high = i_sfr.wdata;
			ADR_TIMER1_COUNT_HIGH:
				st_d.regs.timer1_count_high = i_sfr.wdata;
			ADR_CLOCK_RATE_CONTROL:
				st_d.regs.clock_rate_control = i_sfr.wdata; // RULE15
			default:
				; // RULE16
			endcase
		end

		if (i_sfr.rd)
			st_d.rdata = rd_val;

		unique case (st_q.seq)
		SEQ_IDLE:
			;
		SEQ_RUN:
		begin
			st_d.elapsed = st_q.elapsed + ELAPSED_ONE;
			if (icyc_last)
				st_d.left = st_q.left - MIN_ICYC; // RULE1
			if (finish)
				st_d.seq = SEQ_IDLE;
		end
		endcase

		if (accept)
		begin
			st_d.seq = SEQ_RUN;
			st_d.left = icyc_count(i_op, st_q.regs.clock_rate_control[2:0]);
			st_d.kind = i_op.kind;
			st_d.bytes = i_op.bytes;
			st_d.stretch = st_q.regs.clock_rate_control[2:0];
			st_d.elapsed = ELAPSED_ONE;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (rst)
			st_q <= '{regs: REGS_RST, rdata: 8'h00, seq: SEQ_IDLE,
				left: 4'h0, kind: OP_PLAIN, bytes: 2'h0,
				stretch: 3'h0, elapsed: 6'h00}; // RULE17
		else
			st_q <= st_d;
	end

	// ==============================================================
	// Outputs
	assign o_sfr_rdata = st_q.rdata;
	assign o_data_pointer = ptr_act;
	assign o_pointer_sel = st_q.regs.pointer_choice;
	assign o_op_ready = icyc_last && ((st_q.seq == SEQ_IDLE) || finish);
	assign o_op_done = finish;
	assign o_icycle_end = icyc_last;
	assign o_stretch = st_q.regs.clock_rate_control[2:0]; // RULE18
	assign o_regs = st_q.regs;

	// ==============================================================
	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (rst);

	icyc_four_a: assert property ( // RULE1
		icyc_last |=> !icyc_last [*3] ##1 icyc_last)
		else $error("instruction cycle is not four clocks");

	instr_span_a: assert property ( // RULE2
		finish && st_q.kind != OP_EXT_MOVE |->
		st_q.elapsed >= 6'h04 && st_q.elapsed <= 6'h14)
		else $error("instruction outside one to five cycles");

	dir_move_a: assert property ( // RULE3
		accept && i_op.kind == OP_DIRECT_MOVE |->
		##1 !finish [*8] ##1 !finish [*3] ##1 finish)
		else $error("direct move not twelve clocks");

	ext_fast_a: assert property ( // RULE3
		accept && i_op.kind == OP_EXT_MOVE && o_stretch == 3'h0 |->
		##8 finish)
		else $error("unstretched external move not eight clocks");

	plain_bytes_a: assert property ( // RULE4
		finish && st_q.kind == OP_PLAIN && st_q.bytes != 2'h0 |->
		st_q.elapsed == {2'h0, st_q.bytes, 2'h0})
		else $error("plain instruction cycles differ from bytes");

	mult_long_a: assert property ( // RULE4
		finish && st_q.kind == OP_MULTIPLY |->
		st_q.elapsed > {2'h0, st_q.bytes, 2'h0})
		else $error("multiply not longer than its fetches");

	ext_stretch_a: assert property ( // RULE18
		finish && st_q.kind == OP_EXT_MOVE |->
		st_q.elapsed == {({1'b0, st_q.stretch} + 4'h2), 2'h0})
		else $error("external move not two plus stretch cycles");

	tick_slow_a: assert property ( // RULE5
		o_timer_tick[0] && !o_regs.clock_rate_control[FAST_LSB]
		##1 !o_regs.clock_rate_control[FAST_LSB] [*8]
		##1 !o_regs.clock_rate_control[FAST_LSB] [*3]
		|=> o_timer_tick[0])
		else $error("slow timer rate not twelve clocks");

	// An early tick is legal only during or right after a fast-rate cycle
	tick_gap_a: assert property ( // RULE5
		o_timer_tick[0] && !o_regs.clock_rate_control[FAST_LSB] |=>
		(!o_timer_tick[0] || o_regs.clock_rate_control[FAST_LSB] ||
		$past(o_regs.clock_rate_control[FAST_LSB])) [*8])
		else $error("slow timer ticked early");

	tick_fast_a: assert property ( // RULE6 RULE7
		o_timer_tick[1] && o_regs.clock_rate_control[FAST_LSB + 1]
		##1 o_regs.clock_rate_control[FAST_LSB + 1] [*3]
		|=> o_timer_tick[1])
		else $error("fast timer rate not four clocks");

	sel_second_a: assert property ( // RULE10
		i_sfr.wr && i_sfr.addr == ADR_POINTER_CHOICE &&
		i_sfr.wdata[SEL_BIT] && !i_ptr_load && !i_ptr_inc |=>
		o_data_pointer == {o_regs.pointer_b_high, o_regs.pointer_b_low})
		else $error("select bit did not choose second pointer");

	sel_zero_a: assert property ( // RULE11
		i_sfr.rd && i_sfr.addr == ADR_POINTER_CHOICE |=>
		o_sfr_rdata[7:1] == 7'h00)
		else $error("select register upper bits not zero");

	ptr_inc_a: assert property ( // RULE12
		i_ptr_inc && !i_ptr_load && !i_sfr.wr |=>
		o_data_pointer == $past(o_data_pointer) + 16'h0001)
		else $error("active pointer did not increment");

	sel_toggle_a: assert property ( // RULE13
		i_sfr.wr && i_sfr.addr == ADR_POINTER_CHOICE &&
		i_sfr.wdata == ({7'h00, o_pointer_sel} + 8'h01) |=>
		o_pointer_sel != $past(o_pointer_sel))
		else $error("increment of select did not toggle");

	fixed_ones_a: assert property ( // RULE14
		i_sfr.rd && i_sfr.addr == ADR_POWER_CONTROL |=>
		(o_sfr_rdata & PWR_FIXED_ONES) == PWR_FIXED_ONES)
		else $error("fixed one bits not read as one");

	ptr_read_a: assert property ( // RULE19
		i_sfr.rd && i_sfr.addr == ADR_POINTER_B_LOW |=>
		o_sfr_rdata == $past(o_regs.pointer_b_low))
		else $error("pointer byte read wrong");

	reset_vals_a: assert property (disable iff (1'b0) // RULE17
		$past(rst) && !rst |-> o_regs == REGS_RST)
		else $error("registers not at reset values");

	cover property (accept && i_op.kind == OP_EXT_MOVE);
	cover property (finish && st_q.kind == OP_MULTIPLY);
	cover property (o_timer_tick[2] &&
		o_regs.clock_rate_control[FAST_LSB + 2]);
	cover property (i_sfr.wr && i_sfr.addr == ADR_POINTER_CHOICE
		##1 o_pointer_sel);

endmodule : cpc_sfr_core

// ===== sim/test_cpc_sfr_core.sv
// Self-checking bench for the core register bank: register map,
// data pointers, instruction timing and timer increment rates.
// Assumes cpc_pkg is compiled first; the bench drives every input.
`timescale 1ns/1ps
module test_cpc_sfr_core;
	import cpc_pkg::*;

	// ==============================================================
	// Signals and design
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wdt_rst = 1'b0;
	cpc_sfr_req_type sfr = '0;
	logic ptr_load = 1'b0;
	logic [15:0] ptr_value = 16'h0000;
	logic ptr_inc = 1'b0;
	logic op_valid = 1'b0;
	cpc_op_type op = '0;
	logic [7:0] sfr_rdata;
	logic [15:0] data_pointer;
	logic pointer_sel;
	logic op_ready;
	logic op_done;
	logic icycle_end;
	logic [2:0] timer_tick;
	logic [2:0] stretch;
	cpc_regs_type regs;
	logic [3:0] strobes;
	logic [7:0] mdl [0:15];
	logic [31:0] seed = 32'h5061;
	int num_errors = 0;
	int num_checks = 0;

	assign strobes = {icycle_end, timer_tick};

	always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

	cpc_sfr_core DUT
	(
		.i_sys_clk(sys_clk),
		.i_sys_rst(sys_rst),
		.i_wdt_rst(wdt_rst),
		.i_sfr(sfr),
		.o_sfr_rdata(sfr_rdata),
		.i_ptr_load(ptr_load),
		.i_ptr_value(ptr_value),
		.i_ptr_inc(ptr_inc),
		.o_data_pointer(data_pointer),
		.o_pointer_sel(pointer_sel),
		.i_op_valid(op_valid),
		.i_op(op),
		.o_op_ready(op_ready),
		.o_op_done(op_done),
		.o_icycle_end(icycle_end),
		.o_timer_tick(timer_tick),
		.o_stretch(stretch),
		.o_regs(regs)
	);

	// ==============================================================
	// Expectations
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic [7:0] fixv(input logic [7:0] a,
		input logic [7:0] d);
		if (a == 8'h86)
			return {7'h00, d[0]};
		if (a == 8'h87)
			return d | 8'h30;
		return d;
	endfunction : fixv

	function automatic logic [15:0] op_clocks(input cpc_kind_type k,
		input logic [1:0] b, input logic [2:0] s);
		case (k)
			OP_PLAIN: return (b == 2'h0) ? 16'h0004 : 16'(4 * b);
			OP_DIRECT_MOVE: return 16'h000C;
			OP_EXT_MOVE: return 16'(4 * (2 + s));
			default: return 16'h0014;
		endcase
	endfunction : op_clocks

	task automatic model_reset;
		int i;
		for (i = 0; i < 16; i++)
			mdl[i] = 8'h00;
		mdl[0] = 8'hFF;
		mdl[7] = 8'h30;
		mdl[14] = 8'h01;
	endtask : model_reset

	// ==============================================================
	// Compare tasks
	task automatic flag(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask : flag

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		flag({8'h00, got}, {8'h00, exp});
	endtask : chk_byte

	task automatic chk_word(input logic [15:0] got,
		input logic [15:0] exp);
		flag(got, exp);
	endtask : chk_word

	task automatic chk_count(input logic [15:0] got,
		input logic [15:0] exp);
		flag(got, exp);
	endtask : chk_count

	// ==============================================================
	// Bus and timing tasks
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		sfr.addr = a;
		sfr.wdata = d;
		sfr.wr = 1'b1;
		@(negedge sys_clk);
		sfr.wr = 1'b0;
		if (a >= 8'h80 && a <= 8'h8E)
			mdl[a[3:0]] = fixv(a, d);
		@(negedge sys_clk);
	endtask : wr_reg

	task automatic chk_rd(input logic [7:0] a);
		sfr.addr = a;
		sfr.rd = 1'b1;
		@(negedge sys_clk);
		sfr.rd = 1'b0;
		chk_byte(sfr_rdata, (a >= 8'h80 && a <= 8'h8E) ? mdl[a[3:0]]
			: 8'h00);
		@(negedge sys_clk);
	endtask : chk_rd

	task automatic chk_all;
		int i;
		for (i = 0; i < 16; i++)
			chk_rd(8'h80 + 8'(i));
		chk_byte({7'h00, pointer_sel}, 8'h00);
		chk_byte(regs.power_control, 8'h30);
	endtask : chk_all

	task automatic gap(input int t, input logic [15:0] exp);
		logic [15:0] n;
		int k;
		for (k = 0; k < 40 && strobes[t] !== 1'b1; k++)
			@(negedge sys_clk);
		@(negedge sys_clk);
		n = 16'h0001;
		while (strobes[t] !== 1'b1 && n < 16'h0030)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk_count(n, exp);
	endtask : gap

	task automatic run_op(input cpc_kind_type k, input logic [1:0] b);
		logic [15:0] n;
		int g;
		op.kind = k;
		op.bytes = b;
		op_valid = 1'b1;
		for (g = 0; g < 20 && op_ready !== 1'b1; g++)
			@(negedge sys_clk);
		@(negedge sys_clk);
		op_valid = 1'b0;
		chk_byte({7'h00, op_ready}, 8'h00);
		n = 16'h0001;
		while (op_done !== 1'b1 && n < 16'h0040)
		begin
			@(negedge sys_clk);
			n++;
		end
		chk_count(n, op_clocks(k, b, mdl[14][2:0]));
		@(negedge sys_clk);
	endtask : run_op

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// ==============================================================
	// Watchdog: the tests need some one thousand clocks
	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		num_errors++;
		wrap_up();
	end

	// ==============================================================
	// Main sequence
	initial
	begin
		int i;
		int t;
		logic [7:0] cfg [0:4];
		logic [2:0] sv [0:3];
		cfg = '{8'h01, 8'h09, 8'h11, 8'h21, 8'h39};
		sv = '{3'h0, 3'h1, 3'h3, 3'h7};
		model_reset();
		repeat (16) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk_all();
		chk_word(data_pointer, 16'h0000);
		$display("test reset values done");

		// Random writes skip the reserved place; each drawn place is read
		for (i = 0; i < 60; i++)
		begin
			seed = lfsr_next(seed);
			if (seed[4] && seed[3:0] != 4'hF)
				wr_reg(8'h80 + 8'(seed[3:0]), seed[15:8]);
			chk_rd(8'h80 + 8'(seed[3:0]));
		end
		$display("test register map done");

		wr_reg(8'h82, 8'hA1);
		wr_reg(8'h83, 8'hB2);
		wr_reg(8'h84, 8'hFF);
		wr_reg(8'h85, 8'h12);
		wr_reg(8'h86, 8'hFE);
		chk_word(data_pointer, 16'hB2A1);
		wr_reg(8'h86, 8'h01);
		chk_word(data_pointer, 16'h12FF);
		ptr_inc = 1'b1;
		@(negedge sys_clk);
		ptr_inc = 1'b0;
		chk_word(data_pointer, 16'h1300);
		mdl[4] = 8'h00;
		mdl[5] = 8'h13;
		chk_rd(8'h82);
		chk_rd(8'h84);
		chk_rd(8'h85);
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr_next(seed);
			ptr_value = seed[15:0];
			ptr_load = 1'b1;
			@(negedge sys_clk);
			ptr_load = 1'b0;
			chk_word(data_pointer, seed[15:0]);
			mdl[mdl[6][0] ? 4 : 2] = seed[7:0];
			mdl[mdl[6][0] ? 5 : 3] = seed[15:8];
			chk_rd(mdl[6][0] ? 8'h83 : 8'h85);
			wr_reg(8'h86, mdl[6] + 8'h01);
			chk_byte({7'h00, pointer_sel}, mdl[6]);
		end
		$display("test data pointers done");

		for (i = 0; i < 4; i++)
			run_op(OP_PLAIN, 2'(i));
		run_op(OP_DIRECT_MOVE, 2'h3);
		run_op(OP_MULTIPLY, 2'h1);
		for (i = 0; i < 4; i++)
		begin
			wr_reg(8'h8E, {5'h00, sv[i]});
			chk_byte({5'h00, stretch}, {5'h00, sv[i]});
			run_op(OP_EXT_MOVE, 2'h1);
		end
		gap(3, 16'h0004);
		$display("test instruction timing done");

		for (i = 0; i < 5; i++)
		begin
			wr_reg(8'h8E, cfg[i]);
			for (t = 0; t < 3; t++)
				gap(t, cfg[i][3 + t] ? 16'h0004 : 16'h000C);
		end
		$display("test timer rates done");

		wdt_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		wdt_rst = 1'b0;
		model_reset();
		chk_all();
		chk_word(data_pointer, 16'h0000);
		gap(0, 16'h000C);
		$display("test watchdog reset done");
		wrap_up();
	end

endmodule : test_cpc_sfr_core
